// [hdl/iraccs_pkg.sv]
package iraccs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'hB0;
  localparam logic [7:0] OFFS_OFFSET = 8'hB1;
  localparam logic [7:0] WIN_OFFSET = 8'hB2;
  localparam logic [7:0] ID6_OFFSET = 8'hF5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] OFFS_RESET = 8'h00;
  localparam int SEL_LSB = 2;
  localparam int SEL_MSB = 4;
  localparam int STEP_BIT = 1;
  localparam int PREF_BIT = 0;
  localparam logic [2:0] SEL_PATGEN = 3'h0;
  localparam logic [2:0] SEL_SERTX = 3'h1;
  localparam logic [2:0] SEL_DIEID = 3'h2;
  localparam logic [7:0] PATGEN_FIRST = 8'h01;
  localparam logic [7:0] PATGEN_LAST = 8'h1F;
  localparam logic [7:0] DIEID_FIRST = 8'h00;
  localparam logic [7:0] DIEID_LAST = 8'h0F;
  localparam int MEM_DEPTH = 32;

  typedef struct packed {
    logic [2:0] target_block_select_field;
    logic offset_step_enable;
    logic prefetch_read_enable;
  } iraccs_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iraccs_bus_t;
endpackage : iraccs_pkg

// [hdl/iraccs_mem.sv]
`timescale 1ns/1ps
module iraccs_mem #(
  parameter int DEPTH = 32,
  parameter int AW = 5,
  parameter int DW = 8
) (
  input wire logic mclk, // Clock
  input wire logic reset, // Async reset, high
  input wire logic we, // Write enable
  input wire logic [AW-1:0] waddr, // Write address
  input wire logic [DW-1:0] wdata, // Write data
  input wire logic [AW-1:0] raddr, // Read address
  output logic [DW-1:0] rdata // Registered read data
);
  logic [DW-1:0] mem_r [DEPTH];
  logic [DW-1:0] rdata_nxt;

  always_comb begin
    rdata_nxt = mem_r[raddr];
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      rdata <= rdata_nxt;
      if (we) begin
        mem_r[waddr] <= wdata;
      end
    end
  end
endmodule : iraccs_mem

// [hdl/iraccs_top.sv]
// Summary of operation
// RULE_01: Control, offset and data window sit at main addresses 0xB0, 0xB1 and 0xB2.
// RULE_02: Pattern generator and serial transmitter pages are reachable only through the window.
// RULE_03: Block select picks the page, offset picks the location, the window moves the byte.
// RULE_04: Host writes control, then offset, then the byte to the window to write a page.
// RULE_05: A window write stores the byte at the selected page and offset.
// RULE_06: Host writes control, then offset, then reads the window to read a page.
// RULE_07: With stepping enabled the offset grows by one after each window access.
// RULE_08: Repeated window writes with stepping land in successive offsets.
// RULE_09: Repeated window reads with stepping return successive offsets.
// RULE_10: Select field is control bits 4:2; code 000 maps the pattern page at 0x01 to 0x1F.
// RULE_11: Code 010 maps the sixteen die identification bytes.
// RULE_12: Read-only address 0xF5 returns the sixth identification byte.
// RULE_13: Code 001 maps the serial transmitter page.
// RULE_14: Control bit 1 enables stepping and resets to zero.
// RULE_15: With control bit 0 set an offset write, and a stepped window read, strobe the page.
// RULE_16: The offset register holds a full 8-bit offset.
// RULE_17: Unassigned codes or unmapped offsets read zero and ignore writes.
`timescale 1ns/1ps
module iraccs_top #(
  parameter logic [7:0] SIXTH_ID_BYTE = 8'hA5, // Arbitrary identity value
  parameter logic [127:0] DIE_ID = 128'h0 // Die identification bytes
) (
  input wire logic mclk, // 250 MHz clock
  input wire logic reset, // Async reset, high
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  output logic [7:0] pg_wdata, // Pattern page write data
  output logic [7:0] pg_addr, // Pattern page offset
  output logic pg_wr, // Pattern page write pulse
  output logic [7:0] tx_addr, // Transmitter page offset
  output logic [7:0] tx_wdata, // Transmitter page write data
  output logic tx_wr, // Transmitter page write pulse
  output logic tx_rd, // Transmitter page prefetch strobe
  input wire logic [7:0] tx_rdata // Transmitter page read data
);
  iraccs_pkg::iraccs_bus_t bus;
  iraccs_pkg::iraccs_ctrl_t ctrl_r, ctrl_nxt;
  logic [7:0] offs_r, offs_nxt;
  logic [7:0] rdata_nxt;
  logic [7:0] pg_wdata_nxt, pg_addr_nxt, tx_addr_nxt, tx_wdata_nxt;
  logic pg_wr_nxt, tx_wr_nxt, tx_rd_nxt;
  logic win_wr, win_rd, offs_wr;
  logic pg_hit, die_hit;
  logic [7:0] pg_rdata, die_byte;
  logic [7:0] die_bytes [16];
  logic [4:0] pg_raddr;

  // One byte lane per die identification entry
  for (genvar gi = 0; gi < 16; gi++) begin : g_die
    assign die_bytes[gi] = DIE_ID[8*gi +: 8]; // RULE_11
  end

  assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  always_comb begin
    win_wr = bus.wr && (bus.addr == iraccs_pkg::WIN_OFFSET); // RULE_05
    win_rd = bus.rd && (bus.addr == iraccs_pkg::WIN_OFFSET); // RULE_06
    offs_wr = bus.wr && (bus.addr == iraccs_pkg::OFFS_OFFSET);
    pg_hit = (ctrl_r.target_block_select_field == iraccs_pkg::SEL_PATGEN)
      && (offs_r >= iraccs_pkg::PATGEN_FIRST) && (offs_r <= iraccs_pkg::PATGEN_LAST); // RULE_10
    die_hit = (ctrl_r.target_block_select_field == iraccs_pkg::SEL_DIEID)
      && (offs_r <= iraccs_pkg::DIEID_LAST); // RULE_11
    die_byte = die_bytes[offs_r[3:0]];
    pg_raddr = offs_r[4:0];
  end

  // Pattern page storage; the window read returns its registered output
  iraccs_mem #(
    .DEPTH(iraccs_pkg::MEM_DEPTH),
    .AW(5),
    .DW(8)
  ) u_pg_mem (
    .mclk(mclk),
    .reset(reset),
    .we(win_wr && pg_hit), // RULE_05
    .waddr(offs_r[4:0]),
    .wdata(bus.wdata),
    .raddr(pg_raddr),
    .rdata(pg_rdata)
  );

  logic pg_rd_hit_r, pg_rd_hit_nxt;
  logic [7:0] rdata_r;
  logic [7:0] offs_step;
  logic step_on, pref_on, sel_tx, ctrl_wr;

  // Shared decode of the control fields
  always_comb begin
    step_on = ctrl_r.offset_step_enable;
    pref_on = ctrl_r.prefetch_read_enable;
    sel_tx = (ctrl_r.target_block_select_field == iraccs_pkg::SEL_SERTX); // RULE_13
    ctrl_wr = bus.wr && (bus.addr == iraccs_pkg::CTRL_OFFSET); // RULE_01
    offs_step = offs_r + 8'h01;
  end

  // Control and offset registers
  always_comb begin
    ctrl_nxt = ctrl_r;
    offs_nxt = offs_r;
    if (ctrl_wr) begin
      ctrl_nxt = bus.wdata[4:0]; // RULE_14
    end
    if (offs_wr) begin
      offs_nxt = bus.wdata; // RULE_16
    end
    if ((win_wr || win_rd) && step_on) begin
      offs_nxt = offs_step; // RULE_07 RULE_08 RULE_09
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_r <= iraccs_pkg::CTRL_RESET[4:0]; // RULE_14
      offs_r <= iraccs_pkg::OFFS_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
      offs_r <= offs_nxt;
    end
  end

  // Copy of each pattern page write; other codes and offsets drop it
  always_comb begin
    pg_wr_nxt = 1'b0;
    pg_addr_nxt = pg_addr;
    pg_wdata_nxt = pg_wdata;
    if (win_wr && pg_hit) begin
      pg_wr_nxt = 1'b1; // RULE_03
      pg_addr_nxt = offs_r;
      pg_wdata_nxt = bus.wdata;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pg_wr <= 1'b0;
      pg_addr <= 8'h00;
      pg_wdata <= 8'h00;
    end else begin
      pg_wr <= pg_wr_nxt;
      pg_addr <= pg_addr_nxt;
      pg_wdata <= pg_wdata_nxt;
    end
  end

  // Transmitter page strobes and prefetch
  always_comb begin
    tx_wr_nxt = 1'b0;
    tx_rd_nxt = 1'b0;
    tx_addr_nxt = tx_addr;
    tx_wdata_nxt = tx_wdata;
    if (sel_tx && offs_wr && pref_on) begin
      tx_rd_nxt = 1'b1; // RULE_15
      tx_addr_nxt = bus.wdata;
    end
    if (sel_tx && win_wr) begin
      tx_wr_nxt = 1'b1; // RULE_13
      tx_addr_nxt = offs_r;
      tx_wdata_nxt = bus.wdata;
    end
    if (sel_tx && win_rd && step_on && pref_on) begin
      tx_rd_nxt = 1'b1; // RULE_15
      tx_addr_nxt = offs_step;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_wr <= 1'b0;
      tx_rd <= 1'b0;
      tx_addr <= 8'h00;
      tx_wdata <= 8'h00;
    end else begin
      tx_wr <= tx_wr_nxt;
      tx_rd <= tx_rd_nxt;
      tx_addr <= tx_addr_nxt;
      tx_wdata <= tx_wdata_nxt;
    end
  end

  // Read path; pattern bytes come from the memory output register
  always_comb begin
    rdata_nxt = 8'h00;
    pg_rd_hit_nxt = 1'b0;
    if (bus.rd) begin
      unique case (bus.addr)
        iraccs_pkg::CTRL_OFFSET: rdata_nxt = {3'h0, ctrl_r};
        iraccs_pkg::OFFS_OFFSET: rdata_nxt = offs_r;
        iraccs_pkg::ID6_OFFSET: rdata_nxt = SIXTH_ID_BYTE; // RULE_12
        iraccs_pkg::WIN_OFFSET: begin
          if (die_hit) begin
            rdata_nxt = die_byte; // RULE_11
          end else if (ctrl_r.target_block_select_field == iraccs_pkg::SEL_SERTX) begin
            rdata_nxt = tx_rdata; // RULE_13
          end else begin
            rdata_nxt = 8'h00; // RULE_17
          end
          pg_rd_hit_nxt = pg_hit;
        end
        default: rdata_nxt = 8'h00; // RULE_02
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata_r <= 8'h00;
      pg_rd_hit_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      pg_rd_hit_r <= pg_rd_hit_nxt;
    end
  end

  // Pattern read data comes from the memory output register
  always_comb begin
    reg_rdata = pg_rd_hit_r ? pg_rdata : rdata_r;
  end
endmodule : iraccs_top

// [test/iraccs_chk.sv]
`timescale 1ns/1ps
module iraccs_chk #(
  parameter logic [7:0] SIXTH_ID_BYTE = 8'hA5 // Identity byte
) (
  input wire logic mclk, // Clock
  input wire logic reset, // Reset
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic [7:0] pg_wdata, // Page data
  input wire logic [7:0] pg_addr, // Page offset
  input wire logic pg_wr, // Page write
  input wire logic [7:0] tx_wdata, // Tx data
  input wire logic tx_wr, // Tx write
  input wire logic tx_rd // Tx prefetch
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  a_id_read: assert property (reg_rd && reg_addr == 8'hF5 |=> reg_rdata == SIXTH_ID_BYTE)
    else $error("id byte wrong");
  a_ctrl_back: assert property (reg_wr && reg_addr == 8'hB0 ##1 reg_rd && reg_addr == 8'hB0
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'h1F)) else $error("control readback");
  a_offs_back: assert property (reg_wr && reg_addr == 8'hB1 ##1 reg_rd && reg_addr == 8'hB1
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("offset readback");
  a_pg_cause: assert property (pg_wr |-> $past(reg_wr) && $past(reg_addr) == 8'hB2
    && pg_wdata == $past(reg_wdata)) else $error("page write cause");
  a_pg_range: assert property (pg_wr |-> pg_addr >= 8'h01 && pg_addr <= 8'h1F)
    else $error("page offset range");
  a_tx_cause: assert property (tx_wr |-> $past(reg_wr) && $past(reg_addr) == 8'hB2
    && tx_wdata == $past(reg_wdata)) else $error("tx write cause");
  a_no_wr_else: assert property (reg_wr && reg_addr != 8'hB2 |=> !pg_wr && !tx_wr)
    else $error("stray page write");
  a_pref_cause: assert property (tx_rd |-> $past(reg_wr) && $past(reg_addr) == 8'hB1
    || $past(reg_rd) && $past(reg_addr) == 8'hB2) else $error("stray prefetch");
endmodule : iraccs_chk

bind iraccs_top iraccs_chk #(.SIXTH_ID_BYTE(SIXTH_ID_BYTE)) iraccs_chk_i (.mclk(mclk),
  .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pg_wdata(pg_wdata), .pg_addr(pg_addr), .pg_wr(pg_wr),
  .tx_wdata(tx_wdata), .tx_wr(tx_wr), .tx_rd(tx_rd));

// [test/iraccs_bench.sv]
`timescale 1ns/1ps
module iraccs_bench;
  localparam logic [127:0] DIE = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] tx_rdata = 8'h00;
  logic [7:0] reg_rdata, pg_wdata, pg_addr, tx_addr, tx_wdata, d;
  logic pg_wr, tx_wr, tx_rd;
  logic [7:0] mem [32];
  int miscompares = 0;
  int comparisons = 0;
  int seed = 22;
  int cycles = 0;
  iraccs_top #(.SIXTH_ID_BYTE(8'h5C), .DIE_ID(DIE)) iraccs_top_i (.mclk(mclk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pg_wdata(pg_wdata), .pg_addr(pg_addr), .pg_wr(pg_wr),
    .tx_addr(tx_addr), .tx_wdata(tx_wdata), .tx_wr(tx_wr), .tx_rd(tx_rd), .tx_rdata(tx_rdata));
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, what);
  endtask : rdchk
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rdchk(8'hB0, 8'h00, "ctrl reset");
    rdchk(8'hB1, 8'h00, "offset reset");
    wr(8'hF5, 8'hFF);
    rdchk(8'hF5, 8'h5C, "id byte");
    rdchk(8'h40, 8'h00, "unmapped");
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr(8'hB0, d);
      rdchk(8'hB0, d & 8'h1F, "ctrl rw");
      wr(8'hB1, ~d);
      rdchk(8'hB1, ~d, "offset rw");
    end
    wr(8'hB0, 8'h02);
    wr(8'hB1, 8'h01);
    for (int i = 1; i < 32; i++) begin
      mem[i] = 8'($random(seed));
      wr(8'hB2, mem[i]);
      chk(pg_addr, 8'(i), "pg_addr");
    end
    rdchk(8'hB1, 8'h20, "step wr");
    wr(8'hB1, 8'h01);
    for (int i = 1; i < 32; i++) rdchk(8'hB2, mem[i], "pattern");
    rdchk(8'hB1, 8'h20, "step rd");
    wr(8'hB0, 8'h00);
    wr(8'hB1, 8'h00);
    rdchk(8'hB2, 8'h00, "offset 0");
    wr(8'hB2, 8'h77);
    chk({7'h0, pg_wr}, 8'h00, "pg_wr");
    wr(8'hB1, 8'h05);
    rdchk(8'hB2, mem[5], "fixed 1");
    rdchk(8'hB2, mem[5], "fixed 2");
    wr(8'hB0, 8'h0A);
    wr(8'hB1, 8'h00);
    for (int i = 0; i < 16; i++) rdchk(8'hB2, DIE[8*i +: 8], "die");
    rdchk(8'hB2, 8'h00, "die end");
    d = 8'($random(seed));
    tx_rdata <= d;
    wr(8'hB0, 8'h07);
    wr(8'hB1, 8'h10);
    chk({7'h0, tx_rd}, 8'h01, "prefetch");
    rdchk(8'hB2, d, "tx read");
    chk(tx_addr, 8'h11, "tx step");
    wr(8'hB2, 8'h3C);
    chk(tx_wdata, 8'h3C, "tx write");
    chk({7'h0, tx_wr}, 8'h01, "tx_wr");
    chk(tx_addr, 8'h11, "tx wr addr");
    wr(8'hB0, 8'h0C);
    wr(8'hB1, 8'h01);
    wr(8'hB2, 8'hEE);
    rdchk(8'hB2, 8'h00, "bad code");
    wr(8'hB0, 8'h00);
    rdchk(8'hB2, mem[1], "kept");
    give_verdict();
  end
endmodule : iraccs_bench
